// file: rtl/dps_defines.svh
// Purpose: constants of the dual pot serial slave port
// Assumes: 50 MHz system clock
// Notes:   times kept in their own unit, cycle counts derived
`ifndef DPS_DEFINES_SVH
`define DPS_DEFINES_SVH
`define DPS_CLK_MHZ        50
`define DPS_PROG_TIME_US   5000
`define DPS_PROG_CYCLES    (`DPS_PROG_TIME_US * `DPS_CLK_MHZ)
`define DPS_PUP_TIME_US    1000
`define DPS_PUP_CYCLES     (`DPS_PUP_TIME_US * `DPS_CLK_MHZ)
`define DPS_TYPE_CODE      4'ha
`define DPS_OPC_MSB        7
`define DPS_OPC_LSB        4
`define DPS_REG_MSB        3
`define DPS_REG_LSB        2
`define DPS_POT_MSB        1
`define DPS_POT_LSB        0
`define DPS_OPC_WR_STORED  4'hc
`define DPS_OPC_XFR_STORED 4'he
`define DPS_OPC_GANG_STORE 4'h8
`endif

// file: rtl/dps_pkg.sv
// Purpose: types of the dual pot serial slave port
// Assumes: nothing
// Notes:   one-hot protocol states
package dps_pkg;
    typedef enum logic [6:0] {
        DPS_IDLE  = 7'h01,
        DPS_ADDR  = 7'h02,
        DPS_INSTR = 7'h04,
        DPS_WDATA = 7'h08,
        DPS_RDATA = 7'h10,
        DPS_ACK   = 7'h20,
        DPS_WAIT  = 7'h40
    } dps_state_t;
endpackage

// file: rtl/dps_line_if.sv
// Purpose: synchronised bus line events between modules
// Assumes: one clock domain
// Notes:   events are one-cycle pulses
`timescale 1ns/1ns
interface dps_line_if;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic sdaLevel;
    modport source (output sclRise, sclFall, startSeen, stopSeen, sdaLevel);
    modport sink   (input  sclRise, sclFall, startSeen, stopSeen, sdaLevel);
endinterface

// file: rtl/dps_line_sync.sv
// Purpose: synchronise SCL and SDA and find their events
// Assumes: lines change slower than a few system clocks
// Notes:   first sync stage is read only by the second
`timescale 1ns/1ns
module dps_line_sync (
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rst_b,
    // bus pins
    input  wire logic      sclIn,
    input  wire logic      sdaIn,
    // events
    dps_line_if.source     line
);
    logic [2:0] sclSh;
    logic [2:0] sdaSh;
    logic [2:0] next_sclSh;
    logic [2:0] next_sdaSh;

    always_comb begin
        next_sclSh = {sclSh[1:0], sclIn};
        next_sdaSh = {sdaSh[1:0], sdaIn};
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclSh <= 3'h7;
            sdaSh <= 3'h7;
        end else begin
            sclSh <= next_sclSh;
            sdaSh <= next_sdaSh;
        end
    end

    // stages 1 and 2 are stable copies; stage 0 feeds stage 1 only
    assign line.sclRise   = sclSh[1] & ~sclSh[2];
    assign line.sclFall   = ~sclSh[1] & sclSh[2];
    // sda edge while scl high is never a data bit
    assign line.startSeen = sclSh[1] & sclSh[2] & ~sdaSh[1] & sdaSh[2]; // R1 R5
    assign line.stopSeen  = sclSh[1] & sclSh[2] & sdaSh[1] & ~sdaSh[2]; // R3 R5
    assign line.sdaLevel  = sdaSh[1];
endmodule

// file: rtl/dps_prog_timer.sv
// Purpose: programming-cycle and power-up busy timer
// Assumes: start is a one-cycle pulse
// Notes:   counts are parameters so a bench can shorten them
`timescale 1ns/1ns
module dps_prog_timer #(
    parameter int PROG_CYCLES = 250000,
    parameter int PUP_CYCLES  = 50000
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // control
    input  wire logic start,
    // status
    output logic      busy,
    output logic      ready
);
    initial begin
        if (PROG_CYCLES < 8 || PUP_CYCLES < 2)
            $error("timer counts too small for the pipeline");
    end

    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic        next_busy;
    logic        next_ready;

    always_comb begin
        next_cnt   = cnt;
        next_busy  = busy;
        next_ready = ready;
        if (!ready) begin
            // status flop after ready costs one cycle of the budget
            if (cnt >= 32'(PUP_CYCLES - 2)) begin
                next_ready = 1'b1; // R20
                next_cnt   = 32'h0;
            end else begin
                next_cnt = cnt + 32'h1;
            end
        end else if (start) begin
            next_busy = 1'b1;
            next_cnt  = 32'h0;
        end else if (busy) begin
            // pin sync, start and status flops eat six cycles, so the
            // cycle still ends within PROG_CYCLES of the stop on the pins
            if (cnt >= 32'(PROG_CYCLES - 6)) begin
                next_busy = 1'b0; // R19
                next_cnt  = 32'h0;
            end else begin
                next_cnt = cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt   <= 32'h0;
            busy  <= 1'b0;
            ready <= 1'b0;
        end else begin
            cnt   <= next_cnt;
            busy  <= next_busy;
            ready <= next_ready;
        end
    end

    a_prog_bounded: assert property (@(posedge clk) disable iff (!rst_b)
        busy |-> cnt < 32'(PROG_CYCLES)) // R19
        else $error("programming cycle overran its bound");
endmodule

// file: rtl/dps_serial_port.sv
// Purpose: two-wire slave port of a dual digital potentiometer
// Assumes: master drives scl; pins asynchronous to clk
// Notes:   opcode execution lives outside; this port moves bytes and starts programming after a stored-setting write
// Operation
// R1: start is sda falling while scl high; precedes every command
// R2: ignore all bus activity until a start is seen
// R3: stop is sda rising while scl high
// R4: master ends every operation with a stop
// R5: sda moves only while scl low; high-phase edges are start/stop
// R6: master starts a transfer only when the bus is idle
// R7: master makes scl; this port never drives the clock
// R8: address upper nibble must equal the fixed type code
// R9: address lower nibble must match the four device select pins
// R10: acknowledge a matching address, stay silent on mismatch
// R11: acknowledge is sda held low during the ninth clock
// R12: in write mode acknowledge instruction and data bytes
// R13: read mode sends eight bits then samples master acknowledge
// R14: on master no-acknowledge stop sending, release sda, await stop
// R15: write is start, address, instruction, data, acks, then stop
// R16: instruction is opcode, register select, pot select
// R17: stop after a stored-setting write starts programming
// R18: while programming, sda released and address not acknowledged
// R19: programming ends within 5 ms of the stop
// R20: port ready within 1 ms after power-up
// R21: polling address gets ack only once programming finished
// R22: write-protect low refuses ack of stored-setting data byte
// R23: drive sda only low; mismatch idles until next start
`timescale 1ns/1ns
`include "dps_defines.svh"
module dps_serial_port #(
    parameter int PROG_CYCLES = `DPS_PROG_CYCLES,
    parameter int PUP_CYCLES  = `DPS_PUP_CYCLES
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // bus pins
    input  wire logic       sclIn, // R7
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    // straps and protect
    input  wire logic [3:0] deviceSelect,
    input  wire logic       writeProtect_b,
    // user side
    input  wire logic [7:0] readData,
    output logic [7:0]      instrByte,
    output logic [7:0]      dataByte,
    output logic            instrValid,
    output logic            dataValid,
    output logic            readReq,
    output logic            progBusy
);
    import dps_pkg::*;

    dps_line_if line ();

    logic [3:0] selS1;
    logic [3:0] selS2;
    logic       wpS1;
    logic       wpS2;
    logic       progStart;
    logic       timerBusy;
    logic       timerReady;

    dps_line_sync u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .sclIn (sclIn),
        .sdaIn (sdaIn),
        .line  (line.source)
    );

    dps_prog_timer #(
        .PROG_CYCLES (PROG_CYCLES),
        .PUP_CYCLES  (PUP_CYCLES)
    ) u_timer (
        .clk   (clk),
        .rst_b (rst_b),
        .start (progStart),
        .busy  (timerBusy),
        .ready (timerReady)
    );

    // straps and protect are pins, so they are synchronised too
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            selS1 <= 4'h0;
            selS2 <= 4'h0;
            wpS1  <= 1'b1;
            wpS2  <= 1'b1;
        end else begin
            selS1 <= deviceSelect;
            selS2 <= selS1;
            wpS1  <= writeProtect_b;
            wpS2  <= wpS1;
        end
    end

    dps_state_t state;
    dps_state_t next_state;
    dps_state_t afterAck;
    dps_state_t next_afterAck;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [3:0] bitCnt;
    logic [3:0] next_bitCnt;
    logic       isRead;
    logic       next_isRead;
    logic       ackDrive;
    logic       next_ackDrive;
    logic       storedPend;
    logic       next_storedPend;
    logic       next_sdaOut;
    logic       next_sdaOe;
    logic [7:0] next_instrByte;
    logic [7:0] next_dataByte;
    logic       next_instrValid;
    logic       next_dataValid;
    logic       next_readReq;
    logic       next_progStart;
    logic       storedOp;

    // instruction fields: opcode, register select, pot select
    assign storedOp = (instrByte[`DPS_OPC_MSB:`DPS_OPC_LSB]
                       == `DPS_OPC_WR_STORED); // R16

    always_comb begin
        next_state      = state;
        next_afterAck   = afterAck;
        next_shreg      = shreg;
        next_bitCnt     = bitCnt;
        next_isRead     = isRead;
        next_ackDrive   = ackDrive;
        next_storedPend = storedPend;
        next_sdaOut     = 1'b0; // only ever pulled low R23
        next_sdaOe      = sdaOe;
        next_instrByte  = instrByte;
        next_dataByte   = dataByte;
        next_instrValid = 1'b0;
        next_dataValid  = 1'b0;
        next_readReq    = 1'b0;
        next_progStart  = 1'b0;
        if (timerBusy || !timerReady) begin
            // deaf while programming or powering up
            next_state      = DPS_IDLE; // R18 R21
            next_sdaOe      = 1'b0; // R18
            next_storedPend = 1'b0;
        end else if (line.stopSeen) begin
            next_state      = DPS_IDLE; // R3
            next_sdaOe      = 1'b0;
            next_storedPend = 1'b0;
            next_progStart  = storedPend; // R17
        end else if (line.startSeen) begin
            next_state      = DPS_ADDR; // R1 R2
            next_bitCnt     = 4'h0;
            next_sdaOe      = 1'b0;
            next_storedPend = 1'b0;
        end else begin
            case (state)
            DPS_IDLE, DPS_WAIT: begin
                next_sdaOe = 1'b0; // R2 R14 R23
            end
            DPS_ADDR, DPS_INSTR, DPS_WDATA: begin
                if (line.sclRise) begin
                    next_shreg  = {shreg[6:0], line.sdaLevel};
                    next_bitCnt = bitCnt + 4'h1;
                end else if (line.sclFall && bitCnt == 4'h8) begin
                    next_bitCnt = 4'h0;
                    next_state  = DPS_ACK; // R11
                    next_ackDrive = 1'b1;
                    if (state == DPS_ADDR) begin
                        next_isRead = shreg[0];
                        if (shreg[7:4] != `DPS_TYPE_CODE // R8
                            || shreg[3:0] != selS2) begin // R9
                            next_state = DPS_WAIT; // R10 R23
                            next_ackDrive = 1'b0;
                        end else begin
                            next_afterAck = DPS_INSTR;
                        end
                    end else if (state == DPS_INSTR) begin
                        next_instrByte  = shreg;
                        next_instrValid = 1'b1;
                        next_afterAck   = isRead ? DPS_RDATA : DPS_WDATA;
                        next_readReq    = isRead;
                    end else begin
                        next_dataByte = shreg;
                        next_afterAck = DPS_WAIT; // R15
                        if (storedOp && !wpS2) begin
                            next_ackDrive = 1'b0; // R22
                        end else begin
                            next_dataValid  = 1'b1; // R12
                            next_storedPend = storedOp; // R17
                        end
                    end
                    next_sdaOe = next_ackDrive; // R10 R12
                end
            end
            DPS_ACK: begin
                // held low through the ninth clock
                if (line.sclFall) begin
                    next_sdaOe = 1'b0;
                    next_state = ackDrive ? afterAck : DPS_WAIT;
                    if (ackDrive && afterAck == DPS_RDATA) begin
                        next_shreg = readData;
                        next_sdaOe = ~readData[7];
                    end
                end
            end
            DPS_RDATA: begin
                if (line.sclFall) begin
                    next_bitCnt = bitCnt + 4'h1;
                    if (bitCnt == 4'h7) begin
                        next_sdaOe = 1'b0; // release for master ack R13
                    end else if (bitCnt == 4'h8) begin
                        next_bitCnt = 4'h0;
                        next_shreg  = readData;
                        next_sdaOe  = ~readData[7];
                    end else begin
                        next_shreg = {shreg[6:0], 1'b0};
                        next_sdaOe = ~shreg[6];
                    end
                end else if (line.sclRise && bitCnt == 4'h8) begin
                    if (line.sdaLevel) begin
                        next_state = DPS_WAIT; // R14
                        next_sdaOe = 1'b0;
                    end else begin
                        next_readReq = 1'b1; // R13
                    end
                end
            end
            default: begin
                next_state = DPS_IDLE;
                next_sdaOe = 1'b0;
            end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state      <= DPS_IDLE;
            afterAck   <= DPS_IDLE;
            shreg      <= 8'h00;
            bitCnt     <= 4'h0;
            isRead     <= 1'b0;
            ackDrive   <= 1'b0;
            storedPend <= 1'b0;
            sdaOut     <= 1'b0;
            sdaOe      <= 1'b0;
            instrByte  <= 8'h00;
            dataByte   <= 8'h00;
            instrValid <= 1'b0;
            dataValid  <= 1'b0;
            readReq    <= 1'b0;
            progStart  <= 1'b0;
            progBusy   <= 1'b1;
        end else begin
            state      <= next_state;
            afterAck   <= next_afterAck;
            shreg      <= next_shreg;
            bitCnt     <= next_bitCnt;
            isRead     <= next_isRead;
            ackDrive   <= next_ackDrive;
            storedPend <= next_storedPend;
            sdaOut     <= next_sdaOut;
            sdaOe      <= next_sdaOe;
            instrByte  <= next_instrByte;
            dataByte   <= next_dataByte;
            instrValid <= next_instrValid;
            dataValid  <= next_dataValid;
            readReq    <= next_readReq;
            progStart  <= next_progStart;
            progBusy   <= timerBusy | ~timerReady;
        end
    end

    a_sda_low_only: assert property (@(posedge clk) disable iff (!rst_b)
        sdaOe |-> !sdaOut) // R23
        else $error("sda driven high");
    a_busy_silent: assert property (@(posedge clk) disable iff (!rst_b)
        timerBusy |=> !sdaOe) // R18
        else $error("sda driven while programming");
    a_idle_silent: assert property (@(posedge clk) disable iff (!rst_b)
        (state == DPS_IDLE && !line.startSeen) |=> !sdaOe) // R2
        else $error("sda driven before start");
    a_start_addr: assert property (@(posedge clk) disable iff (!rst_b)
        (line.startSeen && !line.stopSeen && timerReady && !timerBusy)
        |=> state == DPS_ADDR) // R1
        else $error("start not taken");
    a_stop_idle: assert property (@(posedge clk) disable iff (!rst_b)
        line.stopSeen |=> state == DPS_IDLE && !sdaOe) // R3
        else $error("stop not taken");
    a_prog_start: assert property (@(posedge clk) disable iff (!rst_b)
        (line.stopSeen && storedPend && timerReady && !timerBusy)
        |=> progStart ##1 timerBusy) // R17
        else $error("programming not started");
    a_nack_mismatch: assert property (@(posedge clk) disable iff (!rst_b)
        (state == DPS_ADDR && line.sclFall && bitCnt == 4'h8
         && shreg[7:4] != `DPS_TYPE_CODE && !line.startSeen
         && !line.stopSeen && !timerBusy && timerReady)
        |=> state == DPS_WAIT && !sdaOe) // R8 R10
        else $error("foreign address acknowledged");
    a_wp_refuse: assert property (@(posedge clk) disable iff (!rst_b)
        (state == DPS_WDATA && line.sclFall && bitCnt == 4'h8 && storedOp
         && !wpS2 && !line.startSeen && !line.stopSeen
         && !timerBusy && timerReady)
        |=> !sdaOe && !storedPend) // R22
        else $error("protected data byte acknowledged");
    a_master_nack: assert property (@(posedge clk) disable iff (!rst_b)
        (state == DPS_RDATA && line.sclRise && bitCnt == 4'h8
         && line.sdaLevel && !line.startSeen && !line.stopSeen
         && !timerBusy && timerReady)
        |=> state == DPS_WAIT ##1 !sdaOe) // R14
        else $error("kept sending after master nack");
endmodule

// file: sim/dps_master_model.sv
// Purpose: behavioural bus master for the serial slave port
// Assumes: sda is a pulled-up wire resolved by the bench
// Notes:   scl stands high outside frames; lowHold slows the master
`timescale 1ns/1ns
module dps_master_model (
    // bus lines
    output logic      scl,
    output logic      sdaPull,
    input  wire logic sda
);
    int q       = 40;
    int lowHold = 0;

    initial begin
        scl     = 1'b1;
        sdaPull = 1'b0;
    end

    // also serves as repeated start when scl is low
    task automatic start_cond();
        sdaPull = 1'b0;
        #q scl = 1'b1;
        #q sdaPull = 1'b1;
        #q scl = 1'b0;
    endtask

    task automatic stop_cond();
        sdaPull = 1'b1;
        #q scl = 1'b1;
        #q sdaPull = 1'b0;
        #(2*q);
    endtask

    // sda sampled just before scl falls
    task automatic pulse(output logic s);
        #(q+lowHold) scl = 1'b1;
        #(2*q-10) s = sda;
        #10 scl = 1'b0;
    endtask

    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            #q sdaPull = ~b[i];
            pulse(s);
        end
        #q sdaPull = 1'b0;
        pulse(s);
        ack = ~s;
    endtask

    task automatic read_byte(input logic mAck, output logic [7:0] d);
        logic s;
        sdaPull = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #q;
            pulse(s);
            d[i] = s;
        end
        #q sdaPull = mAck;
        pulse(s);
        #q sdaPull = 1'b0;
    endtask
endmodule

// file: sim/dual_pot_serial_slave_port_tb_top.sv
// Purpose: self-checking bench of the serial slave port
// Assumes: shortened program and power-up counts
// Notes:   sda resolved here as a pulled-up open-drain wire
`timescale 1ns/1ns
`include "dps_defines.svh"
module dual_pot_serial_slave_port_tb_top;
    import dps_pkg::*;
    localparam int PROG = 200;
    localparam int PUP  = 50;
    localparam logic [7:0] WADR = {`DPS_TYPE_CODE, 4'h6};
    localparam logic [7:0] RADR = {`DPS_TYPE_CODE, 4'h7};
    logic       clk;
    logic       rst_b;
    logic       scl;
    logic       sdaPull;
    logic       sdaOut;
    logic       sdaOe;
    logic [3:0] deviceSelect;
    logic       writeProtect_b;
    logic [7:0] readData;
    logic [7:0] instrByte;
    logic [7:0] dataByte;
    logic       instrValid;
    logic       dataValid;
    logic       readReq;
    logic       progBusy;
    int         instrCnt = 0;
    int         dataCnt  = 0;
    int         readCnt  = 0;
    int         badDrive = 0;
    int         error_cnt = 0;
    int         checks_done = 0;
    int         cyc       = 0;
    int         stopAt    = 0;
    int         busyEnd   = 0;
    logic [7:0] rdTab [4] = '{8'h00, 8'ha5, 8'h3c, 8'h00};
    wire        sda = ~(sdaOe | sdaPull);

    dps_serial_port #(.PROG_CYCLES(PROG), .PUP_CYCLES(PUP)) dps_serial_port_i (
        .clk(clk), .rst_b(rst_b), .sclIn(scl), .sdaIn(sda),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .deviceSelect(deviceSelect),
        .writeProtect_b(writeProtect_b), .readData(readData),
        .instrByte(instrByte), .dataByte(dataByte),
        .instrValid(instrValid), .dataValid(dataValid),
        .readReq(readReq), .progBusy(progBusy));

    dps_master_model dps_master_model_i (
        .scl(scl), .sdaPull(sdaPull), .sda(sda));

    initial clk = 1'b0;
    always #10 clk = ~clk;

    // stop seen on the wires while the port is free; polls made while busy do not count
    always @(posedge sda)
        if (scl === 1'b1 && progBusy === 1'b0) stopAt = cyc;

    always @(posedge clk) begin
        cyc++;
        if (progBusy === 1'b1) busyEnd = cyc - stopAt;
        if (instrValid === 1'b1) instrCnt++;
        if (dataValid === 1'b1) dataCnt++;
        if (readReq === 1'b1) readCnt++;
        // drive only low, never while programming
        if (rst_b === 1'b1 && sdaOe !== 1'b0 &&
            (sdaOut !== 1'b0 || progBusy !== 1'b0)) badDrive++;
    end

    always @(negedge clk) readData <= rdTab[readCnt[1:0]];

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic xfer(input logic [7:0] ad, input logic [7:0] ins,
                        input logic [7:0] dt, output logic [2:0] acks);
        dps_master_model_i.start_cond();
        dps_master_model_i.write_byte(ad, acks[2]);
        dps_master_model_i.write_byte(ins, acks[1]);
        dps_master_model_i.write_byte(dt, acks[0]);
        dps_master_model_i.stop_cond();
    endtask

    // bounded wait for the busy level to drop
    task automatic wait_free(output int n);
        n = 0;
        while (progBusy !== 1'b0 && n < 2000) begin
            // looked at off the edge that launches it
            @(negedge clk);
            n++;
        end
    endtask

    task automatic poll(output logic a);
        dps_master_model_i.start_cond();
        dps_master_model_i.write_byte(WADR, a);
        dps_master_model_i.stop_cond();
    endtask

    logic [7:0] bad [4] = '{{4'h3, 4'h6}, {`DPS_TYPE_CODE, 4'h4},
                           {`DPS_TYPE_CODE, 4'he}, {4'h2, 4'h6}};
    logic [2:0] acks;
    logic [7:0] d;
    logic       a;
    int         n;

    initial begin
        rst_b = 1'b0;
        writeProtect_b = 1'b1;
        deviceSelect = 4'h6;
        repeat (6) @(posedge clk);
        @(negedge clk) rst_b = 1'b1;
        #1 check("busy_pup", {7'h0, progBusy}, 8'h01);
        wait_free(n);
        check("pup_time", {7'h0, n <= PUP}, 8'h01);
        repeat (5) @(negedge clk);
        // wrong type code or select pins: silent to the next start
        foreach (bad[i]) begin
            xfer(bad[i], 8'h00, 8'h00, acks);
            check("mismatch", {5'h0, acks}, 8'h00);
        end
        check("instr_none", 8'(instrCnt), 8'h00);
        xfer(WADR, {4'ha, 2'b10, 2'b01}, 8'h2d, acks);
        check("wr_acks", {5'h0, acks}, 8'h07);
        check("instr", instrByte, {4'ha, 2'b10, 2'b01});
        check("data", dataByte, 8'h2d);
        check("cnts", 8'(instrCnt * 16 + dataCnt), 8'h11);
        repeat (20) @(negedge clk);
        check("no_prog", {7'h0, progBusy}, 8'h00);
        xfer(WADR, {`DPS_OPC_WR_STORED, 2'b11, 2'b00}, 8'h1e, acks);
        check("st_acks", {5'h0, acks}, 8'h07);
        repeat (10) @(negedge clk);
        check("prog", {7'h0, progBusy}, 8'h01);
        poll(a);
        check("poll_busy", {7'h0, a}, 8'h00);
        wait_free(n);
        check("prog_time", {7'h0, busyEnd <= PROG}, 8'h01);
        poll(a);
        check("poll_done", {7'h0, a}, 8'h01);
        @(negedge clk) writeProtect_b = 1'b0;
        xfer(WADR, {`DPS_OPC_WR_STORED, 2'b01, 2'b01}, 8'h33, acks);
        check("wp_acks", {5'h0, acks}, 8'h06);
        repeat (10) @(negedge clk);
        check("wp_prog", {7'h0, progBusy}, 8'h00);
        check("wp_data", 8'(dataCnt), 8'h02);
        @(negedge clk) writeProtect_b = 1'b1;
        deviceSelect = 4'h7;
        repeat (5) @(negedge clk);
        // slow master on the read to stretch low phases
        dps_master_model_i.lowHold = 200;
        dps_master_model_i.start_cond();
        dps_master_model_i.write_byte(RADR, acks[2]);
        dps_master_model_i.write_byte({4'hb, 2'b01, 2'b00}, acks[1]);
        check("rd_acks", {6'h0, acks[2:1]}, 8'h03);
        dps_master_model_i.read_byte(1'b1, d);
        check("rd0", d, 8'ha5);
        dps_master_model_i.read_byte(1'b0, d);
        check("rd1", d, 8'h3c);
        dps_master_model_i.read_byte(1'b0, d);
        check("rd_after_nack", d, 8'hff);
        dps_master_model_i.stop_cond();
        dps_master_model_i.lowHold = 0;
        check("rd_reqs", 8'(readCnt), 8'h02);
        check("drive", 8'(badDrive), 8'h00);
        results();
    end

    // whole run is near 56 us; a hang ends here
    initial begin
        #500000;
        error_cnt++;
        results();
    end
endmodule
